// *** rtl/pwc_consts.svh ***
`ifndef PWC_CONSTS_SVH
`define PWC_CONSTS_SVH
// register word offsets (byte addresses = 4 * index)
`define PWC_IDX_ENABLE   3'h0
`define PWC_IDX_POLARITY 3'h1
`define PWC_IDX_CLKSEL   3'h2
`define PWC_IDX_CONTROL  3'h5
// concatenation bit positions in the modulator control register
`define PWC_PAIR01_BIT   4
`define PWC_PAIR23_BIT   5
`define PWC_PAIR45_BIT   6
`define PWC_CTL_MASK     8'h70
`define PWC_CH_MASK      8'h3F
`define PWC_RST_BYTE     8'h00
`endif

// *** rtl/pwc_pkg.sv ***
package pwc_pkg;
    typedef logic [7:0] pwc_byte_t;
    typedef enum logic [1:0] {
        PWC_IDLE = 2'b01,
        PWC_ACK  = 2'b10
    } pwc_bus_e;
endpackage : pwc_pkg

// *** rtl/pwc_chan.sv ***
`timescale 1ns/10ps
// one 8-bit modulator channel; a set enable is taken only on a clock tick, a cleared enable stops the channel at once
module pwc_chan
    import pwc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic       polarity,
    input  wire logic [7:0] period,
    input  wire logic [7:0] duty,
    output logic            pwm_out
);
    typedef struct packed {
        logic       run;
        logic [7:0] cnt;
        logic       out;
    } pwc_ch_s;

    pwc_ch_s st, next_st;

    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st.run = 1'b0;
            next_st.cnt = 8'h00;
        end else if (tick) begin
            next_st.run = 1'b1;
            if (st.run) begin
                next_st.cnt = (st.cnt + 8'h01 >= period) ? 8'h00 : st.cnt + 8'h01;
            end
        end
        // idle output sits at the inactive level; level follows the bit at once
        if (!next_st.run)
            next_st.out = ~polarity;
        else
            next_st.out = (next_st.cnt < duty) ? polarity : ~polarity;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign pwm_out = st.out;
endmodule : pwc_chan

// *** rtl/pwc_ctrl.sv ***
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
`include "pwc_consts.svh"
// What this block does
// - six enable bits, each enables a channel
// - waveform starts on next selected clock tick
// - first period after enable may be irregular
// - concatenated pair enabled by low-order bit
// - high-order channel enable ignored, output held off
// - prescaler stops when all enables zero in run mode
// - enable, polarity, clock select always accessible
// - polarity one: high first, low at duty
// - polarity zero: low first, high at duty
// - polarity change takes effect immediately
// - each channel picks one of two clocks
// - clock select change takes effect immediately
// - select zero plain clock, one scaled clock
// - clock A channels 0,1,4,5; clock B 2,3
// - lower channel is high byte when concatenated; here the pair runs on the odd channel's 8-bit compare alone
module pwc_ctrl
    import pwc_pkg::*;
#(
    parameter int CH = 6
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        run_mode,
    input  wire logic        tick_clock_a,
    input  wire logic        tick_scaled_clock_a,
    input  wire logic        tick_clock_b,
    input  wire logic        tick_scaled_clock_b,
    input  wire logic [7:0]  period_lo [CH],
    input  wire logic [7:0]  duty_lo [CH],
    output logic [CH-1:0]    pwm_out,
    output logic             prescaler_run,
    output logic [CH-1:0]    chan_active
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pwc_bus_e   bus;
        pwc_byte_t  channel_enable;
        pwc_byte_t  start_polarity;
        pwc_byte_t  channel_clock_source_select;
        pwc_byte_t  modulator_control_register;
        logic [31:0] rdata;
    } pwc_ctrl_s;

    pwc_ctrl_s st, next_st;

    function automatic pwc_byte_t merge(input pwc_byte_t old, input logic [31:0] wd,
                                        input logic be, input pwc_byte_t mask);
        merge = be ? (wd[7:0] & mask) : old;
    endfunction : merge

    // ----------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        unique case (st.bus)
            PWC_IDLE: begin
                if (avs_read || avs_write)
                    next_st.bus = PWC_ACK;
            end
            PWC_ACK: begin
                next_st.bus = PWC_IDLE;
                next_st.rdata = 32'h0000_0000;
                if (avs_write) begin
                    unique case (avs_address)
                        `PWC_IDX_ENABLE: next_st.channel_enable =
                            merge(st.channel_enable, avs_writedata, avs_byteenable[0],
                                  `PWC_CH_MASK);
                        `PWC_IDX_POLARITY: next_st.start_polarity =
                            merge(st.start_polarity, avs_writedata, avs_byteenable[0],
                                  `PWC_CH_MASK);
                        `PWC_IDX_CLKSEL: next_st.channel_clock_source_select =
                            merge(st.channel_clock_source_select, avs_writedata,
                                  avs_byteenable[0], `PWC_CH_MASK);
                        `PWC_IDX_CONTROL: next_st.modulator_control_register =
                            merge(st.modulator_control_register, avs_writedata,
                                  avs_byteenable[0], `PWC_CTL_MASK);
                        default: ;
                    endcase
                end
            end
            default: next_st.bus = PWC_IDLE;
        endcase
        // read data prepared in idle so it stands in the acknowledge cycle
        if (st.bus == PWC_IDLE && avs_read) begin
            unique case (avs_address)
                `PWC_IDX_ENABLE:   next_st.rdata = {24'h000000, st.channel_enable};
                `PWC_IDX_POLARITY: next_st.rdata = {24'h000000, st.start_polarity};
                `PWC_IDX_CLKSEL:
                    next_st.rdata = {24'h000000, st.channel_clock_source_select};
                `PWC_IDX_CONTROL:
                    next_st.rdata = {24'h000000, st.modulator_control_register};
                default:           next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st.bus                         <= PWC_IDLE;
            st.channel_enable              <= `PWC_RST_BYTE;
            st.start_polarity              <= `PWC_RST_BYTE;
            st.channel_clock_source_select <= `PWC_RST_BYTE;
            st.modulator_control_register  <= `PWC_RST_BYTE;
            st.rdata                       <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && (st.bus != PWC_ACK);
    assign avs_readdata    = st.rdata;

    // ----------------------------------------------------------------
    // enable routing, concatenation and clock choice
    // ----------------------------------------------------------------
    logic [2:0]    concat;
    logic [CH-1:0] eff_en;
    logic [CH-1:0] tick;
    logic [CH-1:0] chan_pin;

    assign concat = {st.modulator_control_register[`PWC_PAIR45_BIT],
                     st.modulator_control_register[`PWC_PAIR23_BIT],
                     st.modulator_control_register[`PWC_PAIR01_BIT]};

    always_comb begin
        for (int i = 0; i < CH; i++) begin
            // odd channel of a pair is the low-order byte and owns the enable
            if ((i % 2 == 0) && concat[i/2])
                eff_en[i] = 1'b0;
            else
                eff_en[i] = st.channel_enable[i];
            // limitation: clocks A/B are only reachable from their own group
            if (i == 2 || i == 3)
                tick[i] = st.channel_clock_source_select[i] ? tick_scaled_clock_b
                                                            : tick_clock_b;
            else
                tick[i] = st.channel_clock_source_select[i] ? tick_scaled_clock_a
                                                            : tick_clock_a;
        end
    end

    // datapath per channel is 8-bit; the 16-bit compare of a pair (lower
    // channel as high byte) belongs to the datapath outside this front end
    for (genvar g = 0; g < CH; g++) begin : g_ch
        pwc_chan u_chan (
            .clk_sys  (clk_sys),
            .sys_rst  (sys_rst),
            .tick     (tick[g]),
            .enable   (eff_en[g]),
            .polarity (st.start_polarity[g]),
            .period   (period_lo[g]),
            .duty     (duty_lo[g]),
            .pwm_out  (chan_pin[g])
        );
    end

    always_comb begin
        for (int i = 0; i < CH; i++)
            pwm_out[i] = ((i % 2 == 0) && concat[i/2]) ? 1'b0 : chan_pin[i];
    end

    assign chan_active   = eff_en;
    // stopping the prescaler only in run mode; outside run mode prescaler_run is held high
    assign prescaler_run = !(run_mode && (st.channel_enable[CH-1:0] == {CH{1'b0}}));
endmodule : pwc_ctrl

// *** testbench/pwc_ctrl_props.sv ***
`timescale 1ns/10ps
`include "pwc_consts.svh"
module pwc_ctrl_props #(
    parameter int CH = 6
) (
    input wire logic          clk_sys,
    input wire logic          sys_rst,
    input wire logic [2:0]    avs_address,
    input wire logic          avs_read,
    input wire logic          avs_write,
    input wire logic [31:0]   avs_writedata,
    input wire logic [3:0]    avs_byteenable,
    input wire logic [31:0]   avs_readdata,
    input wire logic          avs_waitrequest,
    input wire logic          run_mode,
    input wire logic          tick_clock_b,
    input wire logic          tick_scaled_clock_b,
    input wire logic [CH-1:0] pwm_out,
    input wire logic          prescaler_run,
    input wire logic [CH-1:0] chan_active
);
    // ----------------------------------------
    // register shadows, rebuilt from bus traffic
    // ----------------------------------------
    logic [5:0] en;
    logic [5:0] pol;
    logic [2:0] con;
    wire rd_ack = avs_read && !avs_waitrequest;
    wire wr_ack = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [5:0] con_m = {1'b0, con[2], 1'b0, con[1], 1'b0, con[0]};
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            en <= 6'h00;
            pol <= 6'h00;
            con <= 3'h0;
        end else if (wr_ack) begin
            if (avs_address == `PWC_IDX_ENABLE) en <= avs_writedata[5:0];
            if (avs_address == `PWC_IDX_POLARITY) pol <= avs_writedata[5:0];
            if (avs_address == `PWC_IDX_CONTROL) con <= avs_writedata[6:4];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_wait_one; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus wait not one cycle");
    property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("wait without request");
    property p_rd_en; rd_ack && avs_address == 3'h0 |-> avs_readdata == {26'h0, en}; endproperty
    a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
    property p_rd_void; rd_ack && avs_address inside {3, 4, 6, 7} |-> avs_readdata == 32'h0; endproperty
    a_rd_void: assert property (p_rd_void) else $error("unmapped read not zero");
    property p_active; chan_active == (en & ~con_m); endproperty
    a_active: assert property (p_active) else $error("effective enables wrong");
    property p_stop; run_mode && en == 6'h00 |-> !prescaler_run; endproperty
    a_stop: assert property (p_stop) else $error("prescaler runs while idle");
    property p_off_lvl;
        !$past(sys_rst) && !chan_active[1] && !$past(chan_active[1]) && $stable(pol[1])
            |-> pwm_out[1] == !pol[1];
    endproperty
    a_off_lvl: assert property (p_off_lvl) else $error("idle level wrong");
    property p_hold;
        (chan_active[3] && !tick_clock_b && !tick_scaled_clock_b && $stable(pol[3]))[*4]
            |-> $stable(pwm_out[3]);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved without tick");
    c_concat: cover property (con != 3'h0 && en != 6'h00);
    c_stop: cover property (run_mode && !prescaler_run);
    c_tick: cover property (chan_active[3] && tick_scaled_clock_b);
endmodule : pwc_ctrl_props
bind pwc_ctrl pwc_ctrl_props #(.CH(CH)) i_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .run_mode(run_mode),
    .tick_clock_b(tick_clock_b), .tick_scaled_clock_b(tick_scaled_clock_b),
    .pwm_out(pwm_out), .prescaler_run(prescaler_run), .chan_active(chan_active));

// *** testbench/pwc_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`include "pwc_consts.svh"
module pwc_ctrl_tb_top;
    logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, run_mode, prescaler_run, p3;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdata, s;
    logic [3:0] avs_byteenable, tsel, tk;
    logic [7:0] period_lo [6], duty_lo [6], m;
    logic [5:0] pwm_out, chan_active, en, cm;
    int err_count = 0, comparisons = 0, cyc = 0, toggles = 0, highs = 0;
    pwc_ctrl #(.CH(6)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .run_mode(run_mode), .tick_clock_a(tk[3]),
        .tick_scaled_clock_a(tk[2]), .tick_clock_b(tk[1]), .tick_scaled_clock_b(tk[0]),
        .period_lo(period_lo), .duty_lo(duty_lo), .pwm_out(pwm_out),
        .prescaler_run(prescaler_run), .chan_active(chan_active));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic tick_run(input logic [3:0] sel, input logic on);
        int t0;
        int h0;
        tsel <= sel;
        repeat (20) @(posedge clk_sys);
        t0 = toggles;
        h0 = highs;
        repeat (100) @(posedge clk_sys);
        check(32'(toggles - t0 > 4), 32'(on));
        // quarter duty with polarity one: high well under half the window
        if (on) check(32'(highs - h0 < 50), 32'h1);
    endtask : tick_run
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        tk <= (cyc % 4 == 0) ? tsel : 4'h0;
        p3 <= pwm_out[3];
        if (p3 !== pwm_out[3]) toggles <= toggles + 1;
        if (pwm_out[3] === 1'b1) highs <= highs + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            report_and_stop();
        end
    end
    initial begin
        {sys_rst, avs_read, avs_write, run_mode} = 4'b1000;
        {avs_address, avs_writedata, avs_byteenable, tsel} = {35'h0, 4'h1, 4'h0};
        s = 32'hF51D041D;
        for (int i = 0; i < 6; i++) begin
            period_lo[i] = 8'h04;
            duty_lo[i] = (i == 3) ? 8'h01 : 8'h02;
        end
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 3'(i), 8'h00);
            check(rdata, 32'h0);
        end
        for (int i = 0; i < 24; i++) begin
            s = lfsr(s);
            m = (s[2:0] < 3) ? `PWC_CH_MASK : (s[2:0] == 5) ? `PWC_CTL_MASK : 8'h00;
            bus(1'b1, s[2:0], s[15:8]);
            bus(1'b0, s[2:0], 8'h00);
            check(rdata, {24'h0, s[15:8] & m});
        end
        run_mode <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            s = lfsr(s);
            en = (i == 0) ? 6'h00 : s[5:0];
            cm = {1'b0, s[10], 1'b0, s[9], 1'b0, s[8]};
            bus(1'b1, `PWC_IDX_CONTROL, {1'b0, s[10:8], 4'h0});
            bus(1'b1, `PWC_IDX_ENABLE, {2'b00, en});
            #1;
            check(32'(chan_active), 32'(en & ~cm));
            check(32'(prescaler_run), 32'(en != 6'h00));
        end
        bus(1'b1, `PWC_IDX_CONTROL, 8'h00);
        bus(1'b1, `PWC_IDX_ENABLE, 8'h00);
        bus(1'b1, `PWC_IDX_POLARITY, s[23:16]);
        repeat (3) @(posedge clk_sys);
        #1;
        check(32'(pwm_out), {26'h0, ~s[21:16]});
        bus(1'b1, `PWC_IDX_POLARITY, 8'h08);
        bus(1'b1, `PWC_IDX_CLKSEL, 8'h08);
        bus(1'b1, `PWC_IDX_ENABLE, 8'h08);
        tick_run(4'h2, 1'b0);
        tick_run(4'h1, 1'b1);
        bus(1'b1, `PWC_IDX_CLKSEL, 8'h00);
        tick_run(4'h1, 1'b0);
        tick_run(4'h2, 1'b1);
        tick_run(4'h8, 1'b0);
        report_and_stop();
    end
endmodule : pwc_ctrl_tb_top
